// ==== include/uart_shadow_pkg.sv ====
package uart_shadow_pkg;

    // *****************************************************
    // Register map (byte addresses on the Avalon bus)
    // *****************************************************
    localparam logic [31:0] SHADOW_ADDR = 32'h5000_1134;
    localparam logic [31:0] CTRL_ADDR = 32'h5000_1180;
    localparam logic [31:0] STATUS_ADDR = 32'h5000_1184;
    localparam logic [31:0] IRQ_STATUS_ADDR = 32'h5000_1188;
    localparam logic [31:0] IRQ_MASK_ADDR = 32'h5000_118c;

    // *****************************************************
    // Sizes and reset values
    // *****************************************************
    localparam int CHAR_W = 8;
    localparam int FIFO_DEPTH = 16;
    localparam logic [7:0] CHAR_RESET = 8'h00;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;

    // Control register: bit 0 FIFO enable, bit 1 infrared mode
    typedef struct packed {
        logic ir_mode;
        logic fifo_en;
    } ctrl_t;
    localparam ctrl_t CTRL_RESET = '{ir_mode: 1'b0, fifo_en: 1'b0};

    // Status register: live state of the data port
    typedef struct packed {
        logic tx_fifo_full;
        logic rx_fifo_full;
        logic tx_holding_empty;
        logic rx_data_valid;
    } status_t;

    // Sticky event bits; the mask register has the same layout
    typedef struct packed {
        logic tx_empty;
        logic tx_drop;
        logic rx_ready;
        logic rx_overrun;
    } irq_t;
    localparam irq_t IRQ_RESET = '{default: 1'b0};

    // *****************************************************
    // Bus answer sequencing
    // *****************************************************
    typedef enum logic [2:0] {
        BUS_IDLE = 3'b001,
        BUS_PREP = 3'b010,
        BUS_DONE = 3'b100
    } bus_state_t;

endpackage

// ==== logic/shadow_fifo.sv ====
`timescale 1ns/1ps
module shadow_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic clear,
    input wire logic push,
    input wire logic [WIDTH-1:0] push_data,
    input wire logic pop,
    output logic [WIDTH-1:0] head_q,
    output logic head_ok,
    output logic empty,
    output logic full
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
    localparam logic [AW:0] FULL_COUNT = (AW + 1)'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] count_q;
    logic settle_q;

    // Pushes into a full store and pops from an empty one are dropped
    wire do_push = push & ~full;
    wire do_pop = pop & ~empty;
    wire [AW-1:0] wr_next = (wr_q == LAST) ? '0 : wr_q + 1'b1;
    wire [AW-1:0] rd_next = (rd_q == LAST) ? '0 : rd_q + 1'b1;
    assign empty = (count_q == '0);
    assign full = (count_q == FULL_COUNT);
    // Head register lags pointer moves by one edge, so mark it unsettled
    assign head_ok = settle_q & ~empty;

    // Pointers and fill level
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            wr_q <= '0;
            rd_q <= '0;
            count_q <= '0;
            settle_q <= 1'b0;
        end else if (clear) begin
            wr_q <= '0;
            rd_q <= '0;
            count_q <= '0;
            settle_q <= 1'b0;
        end else begin
            if (do_push) begin
                wr_q <= wr_next;
            end
            if (do_pop) begin
                rd_q <= rd_next;
            end
            if (do_push && !do_pop) begin
                count_q <= count_q + 1'b1;
            end else if (do_pop && !do_push) begin
                count_q <= count_q - 1'b1;
            end
            settle_q <= ~(do_push | do_pop);
        end
    end

    // Storage has no reset; only the read register is cleared
    always_ff @(posedge mclk) begin
        if (do_push) begin
            mem[wr_q] <= push_data;
        end
    end

    // Registered head of the queue
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            head_q <= '0;
        end else begin
            head_q <= mem[rd_q];
        end
    end
endmodule

// ==== logic/uart_shadow_data_port.sv ====
`timescale 1ns/1ps
module uart_shadow_data_port #(
    parameter int DEPTH = uart_shadow_pkg::FIFO_DEPTH
) (
    input wire logic mclk,
    input wire logic resetn,
    // Avalon-MM slave
    input wire logic [31:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Receive shifter, same clock
    input wire logic rx_char_valid,
    input wire logic [7:0] rx_char,
    // Transmit shifter, same clock
    output logic tx_char_valid,
    output logic [7:0] tx_char,
    input wire logic tx_char_ready,
    // Link to the rest of the UART
    output logic ir_mode,
    output logic fifo_enable,
    output logic rx_data_valid_flag,
    output logic tx_holding_empty_flag,
    output logic overrun_error,
    output logic irq
);

    // *****************************************************
    // State
    // *****************************************************
    uart_shadow_pkg::bus_state_t state_q;
    uart_shadow_pkg::bus_state_t state_d;
    uart_shadow_pkg::ctrl_t ctrl_q;
    uart_shadow_pkg::irq_t irq_status_q;
    uart_shadow_pkg::irq_t irq_mask_q;
    uart_shadow_pkg::irq_t irq_event;
    uart_shadow_pkg::status_t status;
    logic [31:0] readdata_q;
    logic [31:0] read_mux;
    logic [7:0] rbuf_q;
    logic rbuf_full_q;
    logic [7:0] hold_byte_q;
    logic hold_full_q;
    logic hold_empty_q;
    logic overrun_q;
    logic [7:0] rx_head;
    logic rx_head_ok;
    logic rx_empty;
    logic rx_full;
    logic [7:0] tx_head;
    logic tx_head_ok;
    logic tx_empty;
    logic tx_full;

    // *****************************************************
    // Bus decode
    // *****************************************************
    // Every access takes three cycles so the FIFO head register can
    // settle after a pop before the next read samples it
    wire req = read | write;
    wire take = (state_q == uart_shadow_pkg::BUS_DONE) & req;
    wire sel_shadow = (address == uart_shadow_pkg::SHADOW_ADDR);
    wire sel_ctrl = (address == uart_shadow_pkg::CTRL_ADDR);
    wire sel_status = (address == uart_shadow_pkg::STATUS_ADDR);
    wire sel_irqs = (address == uart_shadow_pkg::IRQ_STATUS_ADDR);
    wire sel_mask = (address == uart_shadow_pkg::IRQ_MASK_ADDR);
    wire low_lane = byteenable[0];
    wire shadow_rd = take & read & sel_shadow;
    wire shadow_wr = take & write & sel_shadow & low_lane;
    wire ctrl_wr = take & write & sel_ctrl & low_lane;
    wire mask_wr = take & write & sel_mask & low_lane;
    wire irqs_rd = take & read & sel_irqs;
    wire fifo_en = ctrl_q.fifo_en;
    uart_shadow_pkg::ctrl_t ctrl_new;
    assign ctrl_new = uart_shadow_pkg::ctrl_t'(writedata[1:0]);
    // Changing the FIFO mode flushes both directions
    wire mode_flush = ctrl_wr & (ctrl_new.fifo_en != fifo_en);

    assign waitrequest = req & (state_q != uart_shadow_pkg::BUS_DONE);
    assign readdata = readdata_q;

    // Answer sequencer
    always_comb begin
        state_d = state_q;
        case (state_q)
            uart_shadow_pkg::BUS_IDLE: begin
                if (req) begin
                    state_d = uart_shadow_pkg::BUS_PREP;
                end
            end
            uart_shadow_pkg::BUS_PREP: begin
                state_d = uart_shadow_pkg::BUS_DONE;
            end
            uart_shadow_pkg::BUS_DONE: begin
                state_d = uart_shadow_pkg::BUS_IDLE;
            end
            default: begin
                state_d = uart_shadow_pkg::BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state_q <= uart_shadow_pkg::BUS_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // *****************************************************
    // Receive path
    // *****************************************************
    wire rx_push = fifo_en & rx_char_valid;
    wire rx_pop = fifo_en & shadow_rd;
    // Full FIFO keeps its contents; the store drops the push
    wire rx_fifo_overrun = rx_push & rx_full;
    wire rx_buf_overrun = ~fifo_en & rx_char_valid & rbuf_full_q
                          & ~shadow_rd;

    shadow_fifo #(
        .WIDTH(uart_shadow_pkg::CHAR_W),
        .DEPTH(DEPTH)
    ) rx_fifo (
        .mclk(mclk),
        .resetn(resetn),
        .clear(mode_flush),
        .push(rx_push),
        .push_data(rx_char),
        .pop(rx_pop),
        .head_q(rx_head),
        .head_ok(rx_head_ok),
        .empty(rx_empty),
        .full(rx_full)
    );

    // Single receive buffer used when FIFOs are off
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rbuf_q <= uart_shadow_pkg::CHAR_RESET;
            rbuf_full_q <= 1'b0;
        end else if (mode_flush) begin
            rbuf_full_q <= 1'b0;
        end else if (!fifo_en && rx_char_valid) begin
            rbuf_q <= rx_char;
            rbuf_full_q <= 1'b1;
        end else if (!fifo_en && shadow_rd) begin
            rbuf_full_q <= 1'b0;
        end
    end

    // With FIFOs on, valid only once the head register has caught up; otherwise the buffer's full bit
    assign rx_data_valid_flag = fifo_en ? rx_head_ok
                                        : rbuf_full_q;

    // *****************************************************
    // Transmit path
    // *****************************************************
    wire tx_push = fifo_en & shadow_wr;
    wire tx_pop = fifo_en & tx_head_ok & tx_char_ready;
    wire tx_dropped = tx_push & tx_full;

    shadow_fifo #(
        .WIDTH(uart_shadow_pkg::CHAR_W),
        .DEPTH(DEPTH)
    ) tx_fifo (
        .mclk(mclk),
        .resetn(resetn),
        .clear(mode_flush),
        .push(tx_push),
        .push_data(writedata[7:0]),
        .pop(tx_pop),
        .head_q(tx_head),
        .head_ok(tx_head_ok),
        .empty(tx_empty),
        .full(tx_full)
    );

    // Holding register; a new write overwrites an unsent character,
    // and a write in the cycle the shifter takes one wins
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            hold_byte_q <= uart_shadow_pkg::CHAR_RESET;
            hold_full_q <= 1'b0;
        end else if (mode_flush) begin
            hold_full_q <= 1'b0;
        end else if (!fifo_en && shadow_wr) begin
            hold_byte_q <= writedata[7:0];
            hold_full_q <= 1'b1;
        end else if (!fifo_en && tx_char_ready) begin
            hold_full_q <= 1'b0;
        end
    end

    // Shifter chooses serial or active-low infrared output by ir_mode
    assign tx_char_valid = fifo_en ? tx_head_ok : hold_full_q;
    assign tx_char = fifo_en ? tx_head : hold_byte_q;
    // Software is expected to wait on this before writing
    assign tx_holding_empty_flag = fifo_en ? tx_empty
                                           : ~hold_full_q;
    assign ir_mode = ctrl_q.ir_mode;
    assign fifo_enable = fifo_en;

    // *****************************************************
    // Control and mask registers
    // *****************************************************
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ctrl_q <= uart_shadow_pkg::CTRL_RESET;
            irq_mask_q <= uart_shadow_pkg::IRQ_RESET;
        end else begin
            if (ctrl_wr) begin
                ctrl_q <= ctrl_new;
            end
            if (mask_wr) begin
                irq_mask_q <= uart_shadow_pkg::irq_t'(writedata[3:0]);
            end
        end
    end

    // *****************************************************
    // Events and interrupt
    // *****************************************************
    assign irq_event.rx_overrun = rx_fifo_overrun | rx_buf_overrun;
    assign irq_event.rx_ready = rx_char_valid & ~rx_fifo_overrun;
    assign irq_event.tx_drop = tx_dropped;
    assign irq_event.tx_empty = tx_holding_empty_flag & ~hold_empty_q;

    // A read clears the sticky bits, but an event in that cycle wins
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            irq_status_q <= uart_shadow_pkg::IRQ_RESET;
            hold_empty_q <= 1'b1;
            overrun_q <= 1'b0;
        end else begin
            if (irqs_rd) begin
                irq_status_q <= irq_event;
            end else begin
                irq_status_q <= irq_status_q | irq_event;
            end
            hold_empty_q <= tx_holding_empty_flag;
            overrun_q <= irq_event.rx_overrun;
        end
    end

    assign overrun_error = overrun_q;
    assign irq = |(irq_status_q & irq_mask_q);

    // *****************************************************
    // Read data
    // *****************************************************
    assign status.rx_data_valid = rx_data_valid_flag;
    assign status.tx_holding_empty = tx_holding_empty_flag;
    assign status.rx_fifo_full = fifo_en & rx_full;
    assign status.tx_fifo_full = fifo_en & tx_full;

    // Upper bits of every word, reserved bits included, read as zero
    wire [7:0] rx_byte = fifo_en ? rx_head : rbuf_q;
    always_comb begin
        read_mux = uart_shadow_pkg::READ_ZERO;
        if (sel_shadow) begin
            read_mux = {24'h00_0000, rx_byte};
        end else if (sel_ctrl) begin
            read_mux = {30'h0000_0000, ctrl_q};
        end else if (sel_status) begin
            read_mux = {28'h000_0000, status};
        end else if (sel_irqs) begin
            read_mux = {28'h000_0000, irq_status_q};
        end else if (sel_mask) begin
            read_mux = {28'h000_0000, irq_mask_q};
        end
    end

    // Captured one cycle before the answer; unmapped reads give zero
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            readdata_q <= uart_shadow_pkg::READ_ZERO;
        end else if (state_q == uart_shadow_pkg::BUS_PREP && read) begin
            readdata_q <= read_mux;
        end
    end

endmodule

// ==== tb/uart_far_end.sv ====
`timescale 1ns/1ps
module uart_far_end (
    input wire logic mclk,
    output logic rx_char_valid,
    output logic [7:0] rx_char,
    input wire logic tx_char_valid,
    input wire logic [7:0] tx_char,
    output logic tx_char_ready
);
    logic stall = 1'b1;
    logic [7:0] got[$];

    // Idle line at time zero
    initial begin
        rx_char_valid = 1'b0;
        rx_char = 8'h00;
        tx_char_ready = 1'b0;
    end

    // Ready wanders so that both prompt and slow takes occur
    always @(posedge mclk) begin
        tx_char_ready <= !stall && ($urandom % 3 != 0);
        if (tx_char_valid && tx_char_ready) begin
            got.push_back(tx_char);
        end
    end

    // One received character, a single-cycle pulse
    task automatic send(input logic [7:0] c);
        @(posedge mclk);
        rx_char_valid <= 1'b1;
        rx_char <= c;
        @(posedge mclk);
        rx_char_valid <= 1'b0;
        rx_char <= ~c; // Stale byte must not pass for fresh data
    endtask
endmodule

// ==== tb/uart_shadow_chk.sv ====
`timescale 1ns/1ps
module uart_shadow_chk #(
    parameter int DEPTH = 16
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [31:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    input wire logic rx_char_valid,
    input wire logic [7:0] rx_char,
    input wire logic tx_char_valid,
    input wire logic [7:0] tx_char,
    input wire logic tx_char_ready,
    input wire logic ir_mode,
    input wire logic fifo_enable,
    input wire logic rx_data_valid_flag,
    input wire logic tx_holding_empty_flag,
    input wire logic overrun_error,
    input wire logic irq
);
    // ********************************
    // Accepted accesses
    // ********************************
    wire logic sh = address == uart_shadow_pkg::SHADOW_ADDR;
    wire logic take = (read | write) & ~waitrequest;
    wire logic sh_wr = take & write & sh & byteenable[0];
    logic [7:0] wr_byte_q;

    // Last shadow byte, so the delayed fifo head can be matched
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            wr_byte_q <= 8'h00;
        end else if (sh_wr) begin
            wr_byte_q <= writedata[7:0];
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);

    // ********************************
    // Properties
    // ********************************
    property p_two_waits;
        take |-> $past(waitrequest, 1) && $past(waitrequest, 2);
    endproperty
    a_two_waits: assert property (p_two_waits)
        else $error("bus answer without two wait cycles");
    property p_idle;
        !(read | write) |-> !waitrequest;
    endproperty
    a_idle: assert property (p_idle)
        else $error("wait asserted with no request");
    property p_hi_zero;
        take && read |-> readdata[31:8] == 24'h0;
    endproperty
    a_hi_zero: assert property (p_hi_zero)
        else $error("upper read bits not zero");
    property p_empty_clr;
        sh_wr && !fifo_enable && tx_holding_empty_flag
            |=> !tx_holding_empty_flag;
    endproperty
    a_empty_clr: assert property (p_empty_clr)
        else $error("holding empty flag stayed set");
    property p_hold_load;
        sh_wr && !fifo_enable
            |=> tx_char_valid && tx_char == $past(writedata[7:0]);
    endproperty
    a_hold_load: assert property (p_hold_load)
        else $error("holding byte not the one written");
    property p_fifo_load;
        sh_wr && fifo_enable && tx_holding_empty_flag
            |-> ##[1:4] (tx_char_valid && tx_char == wr_byte_q);
    endproperty
    a_fifo_load: assert property (p_fifo_load)
        else $error("fifo head not offered to sender");
    property p_ovr_nofifo;
        rx_char_valid && !fifo_enable && rx_data_valid_flag && !take
            |=> overrun_error;
    endproperty
    a_ovr_nofifo: assert property (p_ovr_nofifo)
        else $error("overwrite without overrun");
    property p_ovr_cause;
        overrun_error |-> $past(rx_char_valid);
    endproperty
    a_ovr_cause: assert property (p_ovr_cause)
        else $error("overrun without an arriving char");
    property p_rx_set;
        rx_char_valid && !fifo_enable && !take |=> rx_data_valid_flag;
    endproperty
    a_rx_set: assert property (p_rx_set)
        else $error("data valid flag not set");

    // Main scenarios reached
    c_fifo_wr: cover property (sh_wr && fifo_enable);
    c_overrun: cover property (overrun_error);
    c_irq: cover property (irq);
endmodule

bind uart_shadow_data_port uart_shadow_chk #(.DEPTH(DEPTH)) chk_i (
    .mclk(mclk), .resetn(resetn), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest),
    .rx_char_valid(rx_char_valid), .rx_char(rx_char),
    .tx_char_valid(tx_char_valid), .tx_char(tx_char),
    .tx_char_ready(tx_char_ready), .ir_mode(ir_mode),
    .fifo_enable(fifo_enable), .rx_data_valid_flag(rx_data_valid_flag),
    .tx_holding_empty_flag(tx_holding_empty_flag),
    .overrun_error(overrun_error), .irq(irq)
);

// ==== tb/uart_shadow_data_port_tb.sv ====
`timescale 1ns/1ps
module uart_shadow_data_port_tb;
    localparam int DEPTH = 4;
    localparam logic [31:0] SH = uart_shadow_pkg::SHADOW_ADDR;
    localparam logic [31:0] CT = uart_shadow_pkg::CTRL_ADDR;
    localparam logic [31:0] ST = uart_shadow_pkg::STATUS_ADDR;
    localparam logic [31:0] IS = uart_shadow_pkg::IRQ_STATUS_ADDR;
    localparam logic [31:0] IM = uart_shadow_pkg::IRQ_MASK_ADDR;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic [31:0] address, writedata, readdata, q;
    logic read, write, waitrequest, rx_char_valid, tx_char_valid;
    logic tx_char_ready, ir_mode, fifo_enable, rx_dv, tx_he, ovr, irq;
    logic [3:0] byteenable;
    logic [7:0] rx_char, tx_char, c;
    logic [7:0] b[$];
    logic [31:0] regs [5] = '{SH, CT, IS, IM, 32'h5000_11f0};
    int n_ovr = 0;
    int n_errors = 0;
    int check_count = 0;

    always #5 mclk = ~mclk;

    // Overrun pin is a one-cycle pulse, so count it at every edge
    always @(posedge mclk) begin
        if (ovr === 1'b1) begin
            n_ovr++;
        end
    end

    uart_shadow_data_port #(.DEPTH(DEPTH)) uart_shadow_data_port_i (
        .mclk(mclk), .resetn(resetn), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest),
        .rx_char_valid(rx_char_valid), .rx_char(rx_char),
        .tx_char_valid(tx_char_valid), .tx_char(tx_char),
        .tx_char_ready(tx_char_ready), .ir_mode(ir_mode),
        .fifo_enable(fifo_enable), .rx_data_valid_flag(rx_dv),
        .tx_holding_empty_flag(tx_he), .overrun_error(ovr), .irq(irq));
    uart_far_end far_i (.mclk(mclk), .rx_char_valid(rx_char_valid),
        .rx_char(rx_char), .tx_char_valid(tx_char_valid),
        .tx_char(tx_char), .tx_char_ready(tx_char_ready));

    // ********************************
    // Checking and bus tasks
    // ********************************
    task automatic final_report();
        if (n_errors == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, g);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    function automatic logic [31:0] st(input logic dv, he, rf, tf);
        return {28'h0, tf, rf, he, dv};
    endfunction
    // Request held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic w, input logic [31:0] a, d,
                       input logic [3:0] be);
        int n;
        n = 0;
        @(posedge mclk);
        read <= !w;
        write <= w;
        address <= a;
        writedata <= d;
        byteenable <= be;
        do begin
            @(posedge mclk);
            n++;
        end while (waitrequest !== 1'b0 && n < 20);
        if (waitrequest !== 1'b0) begin
            chk("bus timeout", 32'h1, 32'h0);
            final_report();
        end
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a, m, e, input string nm);
        bus(1'b0, a, 32'h0, 4'h1);
        chk(nm, e, q & m);
    endtask
    task automatic wait_tx(input int k);
        int n;
        for (n = 0; n < 500 && far_i.got.size() < k; n++) begin
            @(posedge mclk);
        end
        chk("tx count", 32'(k), 32'(far_i.got.size()));
        if (far_i.got.size() < k) begin
            final_report();
        end
    endtask

    // ********************************
    // Main sequence
    // ********************************
    initial begin
        {address, writedata, byteenable, read, write} = '0;
        void'($urandom(32'h816745cb));
        repeat (5) @(posedge mclk);
        resetn <= 1'b1;
        rd(ST, 32'hf, st(0, 1, 0, 0), "status reset");
        foreach (regs[i]) begin
            rd(regs[i], '1, 32'h0, "reset");
        end
        // Single buffer: read, then overwrite with overrun
        c = 8'($urandom);
        far_i.send(c);
        rd(ST, 32'h1, 32'h1, "data valid");
        chk("dv pin", 32'h1, {31'h0, rx_dv});
        rd(SH, '1, {24'h0, c}, "rx byte");
        rd(ST, 32'h1, 32'h0, "data gone");
        bus(1'b1, IM, 32'h1, 4'h1);
        far_i.send(c);
        far_i.send(~c);
        repeat (3) @(posedge mclk);
        chk("irq on", 32'h1, {31'h0, irq});
        chk("overrun pin", 32'h1, 32'(n_ovr));
        rd(IS, 32'h1, 32'h1, "overrun");
        @(posedge mclk);
        chk("irq off", 32'h0, {31'h0, irq});
        rd(SH, '1, {24'h0, ~c}, "overwritten");
        // Holding register with the far side stalled
        rd(ST, 32'h2, 32'h2, "holding free");
        bus(1'b1, SH, {24'h0, c}, 4'h1);
        rd(ST, 32'h2, 32'h0, "holding busy");
        chk("he pin", 32'h0, {31'h0, tx_he});
        bus(1'b1, SH, {24'hffffff, ~c}, 4'h1);
        bus(1'b1, SH, 32'h5a, 4'h0);
        far_i.stall <= 1'b0;
        wait_tx(1);
        chk("tx byte", {24'h0, ~c}, {24'h0, far_i.got[0]});
        bus(1'b1, CT, 32'h2, 4'h1);
        @(posedge mclk);
        chk("ir mode", 32'h1, {31'h0, ir_mode});
        // Fifo transmit: one past the depth while stalled
        far_i.stall <= 1'b1;
        far_i.got.delete();
        bus(1'b1, CT, 32'h1, 4'h1);
        @(posedge mclk);
        chk("fifo on", 32'h1, {31'h0, fifo_enable});
        for (int i = 0; i <= DEPTH; i++) begin
            b.push_back(8'($urandom));
            bus(1'b1, SH, {24'h0, b[i]}, 4'h1);
        end
        rd(ST, 32'h8, 32'h8, "tx full");
        rd(IS, 32'h4, 32'h4, "tx drop");
        far_i.stall <= 1'b0;
        wait_tx(DEPTH);
        rd(ST, 32'h2, 32'h2, "tx empty");
        chk("tx total", 32'(DEPTH), 32'(far_i.got.size()));
        for (int i = 0; i < DEPTH; i++) begin
            chk("tx fifo", {24'h0, b[i]}, {24'h0, far_i.got[i]});
        end
        // Fifo receive: one past the depth before any read
        b.delete();
        for (int i = 0; i <= DEPTH; i++) begin
            b.push_back(8'($urandom));
            far_i.send(b[i]);
        end
        rd(ST, 32'h4, 32'h4, "rx full");
        rd(IS, 32'h1, 32'h1, "rx overrun");
        chk("overrun pin", 32'h2, 32'(n_ovr));
        for (int i = 0; i < DEPTH; i++) begin
            rd(SH, '1, {24'h0, b[i]}, "rx fifo");
        end
        rd(ST, 32'h1, 32'h0, "rx empty");
        final_report();
    end
endmodule
